// *** rtl/basic_timer_watchdog_control.sv ***
// Basic timer control register, 8-bit counter and watchdog enable.
// The count and the enable go to watchdog reset logic outside.
// Assumes an 8-bit register bus with write and read strobes, and
// that clk_i is the selected system clock fxx.
// All inputs but rst_i are taken as synchronous to clk_i; rst_i resets asynchronously.
// Functional notes
// - Code 1010 in bits 7..4 disables watchdog.
// - Bits 3..2 select divide 4096/1024/128/16.
// - Bit 1 write-one clears count, self-clears.
// - Bit 0 write-one clears dividers, self-clears.
// - Dividers run from selected system clock.
// - Divider clear is shared with timer/counters.
// - Count readable read-only at its address.
module basic_timer_watchdog_control
  import bt_wdt_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus
  input wire bus_req_type bus_i,
  output logic [7:0] rdata_o,
  // Status toward the rest of the chip
  output logic wdt_enable_o,
  output logic div_clear_o,
  output logic [7:0] count_o,
  output logic overflow_o
);

  // Decoded bus strobes, shared by every register group below.
  logic ctrl_hit;
  logic count_hit;
  logic ctrl_wr;
  logic ctrl_rd;
  logic count_rd;
  logic cnt_clr;
  logic div_clr;

  // Control register and the clock selection taken from it.
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  clk_sel_type sel;

  // Basic timer count, its tick and its wrap pulse.
  logic tick;
  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic ovf_reg;
  logic ovf_next;

  // Watchdog enable level and the shared divider clear pulse.
  logic wdt_en_reg;
  logic wdt_en_next;
  logic div_clr_reg;
  logic div_clr_next;

  // Read data, held for the one cycle after a read strobe.
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // True while the code field leaves the watchdog armed; any code but
  // the disable pattern keeps it able to reset the system.
  function automatic logic wdt_armed(input logic [3:0] code);
    return (code != WD_DISABLE_CODE);
  endfunction : wdt_armed

  // One step of the 8-bit count; the carry out of the top is dropped,
  // so the count wraps back to zero.
  function automatic logic [7:0] count_step(input logic [7:0] value);
    return value + 8'h01;
  endfunction : count_step

  // Read multiplexer; idle cycles and unmapped addresses give zero.
  function automatic logic [7:0] read_mux(
    input logic sel_ctrl,
    input logic sel_count,
    input logic [7:0] ctrl_val,
    input logic [7:0] count_val
  );
    logic [7:0] value;
    value = RDATA_IDLE;
    if (sel_ctrl) begin
      value = ctrl_val;
    end else if (sel_count) begin
      value = count_val;
    end
    return value;
  endfunction : read_mux

  // Only the two mapped addresses decode; all others are ignored, and
  // reads of them return zero.
  always_comb begin
    ctrl_hit = (bus_i.addr == CTRL_ADDR);
    count_hit = (bus_i.addr == COUNT_ADDR);
    ctrl_wr = bus_i.wr && ctrl_hit;
    ctrl_rd = bus_i.rd && ctrl_hit;
    // No write strobe is formed for the count, so it stays read-only.
    count_rd = bus_i.rd && count_hit;
    cnt_clr = ctrl_wr && bus_i.wdata[CNT_CLR_BIT];
    div_clr = ctrl_wr && bus_i.wdata[DIV_CLR_BIT];
  end

  assign sel = clk_sel_type'(ctrl_reg[CLK_SEL_MSB:CLK_SEL_LSB]);

  // The prescaler runs on clk_i, which is fxx itself, so a change of
  // oscillator upstream scales every tick period with it. The
  // timer/counters restart one cycle after this prescaler on a clear.
  bt_prescaler u_prescaler (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(div_clr),
    .sel_i(sel),
    .tick_o(tick)
  );

  // Control register: a write loads bits 7..2 at once; the clear bits stay zero.
  always_comb begin
    ctrl_next = ctrl_reg;
    if (ctrl_wr) begin
      ctrl_next = bus_i.wdata;
    end
    // Clear bits never hold a one, so reads always show zero there.
    ctrl_next[CNT_CLR_BIT] = 1'b0;
    ctrl_next[DIV_CLR_BIT] = 1'b0;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_reg <= CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Count: a clear wins over a tick that lands in the same cycle.
  always_comb begin
    count_next = count_reg;
    if (cnt_clr) begin
      count_next = COUNT_RESET;
    end else if (tick) begin
      count_next = count_step(count_reg);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_reg <= COUNT_RESET;
    end else begin
      count_reg <= count_next;
    end
  end

  // Wrap pulse for the watchdog reset logic outside; a clear in the
  // wrap cycle suppresses it, since no wrap then takes place.
  always_comb begin
    if (cnt_clr) begin
      ovf_next = 1'b0;
    end else if (tick) begin
      ovf_next = (count_reg == COUNT_MAX);
    end else begin
      ovf_next = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ovf_reg <= 1'b0;
    end else begin
      ovf_reg <= ovf_next;
    end
  end

  // Decoding the next control value lets the enable change in the
  // same cycle as the code field itself.
  always_comb begin
    wdt_en_next = wdt_armed(ctrl_next[WD_CODE_MSB:WD_CODE_LSB]);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wdt_en_reg <= WDT_EN_RESET;
    end else begin
      wdt_en_reg <= wdt_en_next;
    end
  end

  // The pulse is exported through a register, so the timer/counters clear
  // one cycle after the prescaler here.
  always_comb begin
    div_clr_next = div_clr;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_clr_reg <= 1'b0;
    end else begin
      div_clr_reg <= div_clr_next;
    end
  end

  // Read data: the multiplexer output is registered for one cycle. A
  // read in the cycle of a write returns the value before the write.
  always_comb begin
    rdata_next = read_mux(ctrl_rd, count_rd, ctrl_reg, count_reg);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_reg <= RDATA_IDLE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Every output comes straight from a flip-flop.
  assign rdata_o = rdata_reg;
  assign wdt_enable_o = wdt_en_reg;
  assign div_clear_o = div_clr_reg;
  assign count_o = count_reg;
  assign overflow_o = ovf_reg;

endmodule : basic_timer_watchdog_control

// *** rtl/bt_prescaler.sv ***
// Free-running prescaler that yields the basic timer tick enable.
// Assumes clk_i is the selected system clock fxx.
module bt_prescaler
  import bt_wdt_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic clear_i,
  input wire clk_sel_type sel_i,
  // Tick
  output logic tick_o
);

  logic [DIV_WIDTH-1:0] div_reg;
  logic [DIV_WIDTH-1:0] div_next;
  logic tick_reg;
  logic tick_next;
  logic [DIV_WIDTH-1:0] mask;

  always_comb begin
    unique case (sel_i)
      SEL_DIV4096: mask = DIV_MASK_4096;
      SEL_DIV1024: mask = DIV_MASK_1024;
      SEL_DIV128: mask = DIV_MASK_128;
      SEL_DIV16: mask = DIV_MASK_16;
    endcase
    // A clear restarts the division from zero with no tick issued.
    if (clear_i) begin
      div_next = '0;
      tick_next = 1'b0;
    end else begin
      div_next = div_reg + 12'h001;
      tick_next = ((div_reg & mask) == mask);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      tick_reg <= tick_next;
    end
  end

  assign tick_o = tick_reg;

endmodule : bt_prescaler

// *** rtl/bt_wdt_pkg.sv ***
// Package for the basic timer / watchdog control block.
// Assumes an 8-bit internal register bus with single-cycle access.
package bt_wdt_pkg;

  localparam logic [7:0] CTRL_ADDR = 8'hD3;
  localparam logic [7:0] COUNT_ADDR = 8'hFD;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] RDATA_IDLE = 8'h00;
  localparam logic WDT_EN_RESET = 1'b1;

  localparam int WD_CODE_MSB = 7;
  localparam int WD_CODE_LSB = 4;
  localparam int CLK_SEL_MSB = 3;
  localparam int CLK_SEL_LSB = 2;
  localparam int CNT_CLR_BIT = 1;
  localparam int DIV_CLR_BIT = 0;

  localparam logic [3:0] WD_DISABLE_CODE = 4'hA;

  localparam int DIV_WIDTH = 12;
  localparam logic [11:0] DIV_MASK_4096 = 12'hFFF;
  localparam logic [11:0] DIV_MASK_1024 = 12'h3FF;
  localparam logic [11:0] DIV_MASK_128 = 12'h07F;
  localparam logic [11:0] DIV_MASK_16 = 12'h00F;

  typedef enum logic [1:0] {
    SEL_DIV4096 = 2'b00,
    SEL_DIV1024 = 2'b01,
    SEL_DIV128 = 2'b10,
    SEL_DIV16 = 2'b11
  } clk_sel_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_type;

endpackage : bt_wdt_pkg

// *** tb/bt_wdt_asserts.sv ***
// Concurrent checks on the timer control block's ports.
// Assumes it is bound to the top module and sees only its ports.
module bt_wdt_asserts
  import bt_wdt_pkg::*;
(
  // Clock, reset and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire bus_req_type bus_i,
  // Outputs watched
  input wire logic [7:0] rdata_o,
  input wire logic wdt_enable_o,
  input wire logic div_clear_o,
  input wire logic [7:0] count_o,
  input wire logic overflow_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence ctrl_wr;
    bus_i.wr && bus_i.addr == CTRL_ADDR;
  endsequence
  AST_WD_OFF: assert property (ctrl_wr ##0
    bus_i.wdata[7:4] == WD_DISABLE_CODE |=> !wdt_enable_o)
    else $error("watchdog stayed on");
  AST_WD_ON: assert property (ctrl_wr ##0
    bus_i.wdata[7:4] != WD_DISABLE_CODE |=> wdt_enable_o)
    else $error("watchdog stayed off");
  AST_WD_HOLD: assert property (!(bus_i.wr &&
    bus_i.addr == CTRL_ADDR) |=> $stable(wdt_enable_o))
    else $error("watchdog enable changed without a write");
  AST_CNT_CLR: assert property (ctrl_wr ##0 bus_i.wdata[1]
    |=> count_o == 8'h00) else $error("count not cleared");
  AST_DIV_CLR: assert property (ctrl_wr ##0 bus_i.wdata[0]
    |=> div_clear_o) else $error("divider clear missing");
  AST_DIV_CAUSE: assert property (div_clear_o |->
    $past(bus_i.wr && bus_i.addr == CTRL_ADDR && bus_i.wdata[0]))
    else $error("divider clear without cause");
  AST_CNT_RD: assert property (bus_i.rd && bus_i.addr == COUNT_ADDR
    |=> rdata_o == $past(count_o)) else $error("count read wrong");
  AST_CTRL_RD: assert property (bus_i.rd && bus_i.addr == CTRL_ADDR
    |=> rdata_o[1:0] == 2'b00) else $error("clear bits read back");
  AST_STEP: assert property (count_o != $past(count_o) |->
    count_o == 8'h00 || count_o == $past(count_o) + 8'h01)
    else $error("count jumped");
  AST_OVF: assert property (overflow_o |-> count_o == 8'h00)
    else $error("overflow without wrap");
  AST_OVF_PULSE: assert property (overflow_o |=> !overflow_o)
    else $error("overflow pulse too long");
endmodule : bt_wdt_asserts

// *** tb/tb.sv ***
// Directed register test of the timer control block.
// Assumes a 20 MHz clock and the single-cycle strobe bus.
module tb import bt_wdt_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  bus_req_type bus_i = '0;
  logic [7:0] rdata_o, count_o;
  logic wdt_enable_o, div_clear_o, overflow_o;
  int err_total = 0;
  int check_count = 0;
  int dv[4] = '{4096, 1024, 128, 16};
  always #25 clk_i = ~clk_i;
  basic_timer_watchdog_control basic_timer_watchdog_control_i (.clk_i,
    .rst_i, .bus_i, .rdata_o, .wdt_enable_o, .div_clear_o, .count_o,
    .overflow_o);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %h vs %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    bus_i = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(negedge clk_i);
    bus_i.wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_i);
    bus_i = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(negedge clk_i);
    bus_i.rd = 1'b0;
    chk(rdata_o, exp);
  endtask : rd
  task test_done;
    if (err_total == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done
  initial begin
    #2000000;
    err_total++;
    test_done();
  end
  initial begin
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    rd(CTRL_ADDR, CTRL_RESET);
    chk({7'h00, wdt_enable_o}, 8'h01);
    wr(CTRL_ADDR, 8'hA6);
    chk({7'h00, wdt_enable_o}, 8'h00);
    rd(CTRL_ADDR, 8'hA4);
    wr(CTRL_ADDR, 8'h9D);
    chk({7'h00, div_clear_o}, 8'h01);
    chk({7'h00, wdt_enable_o}, 8'h01);
    rd(8'hD0, 8'h00);
    // Waiting two and a half periods keeps the expected count of two
    // safe against a cycle of slack in where the first tick lands.
    for (int s = 0; s < 4; s++) begin
      wr(CTRL_ADDR, {4'hA, s[1:0], 2'b11});
      chk(count_o, 8'h00);
      chk({7'h00, div_clear_o}, 8'h01);
      wr(COUNT_ADDR, 8'hFF);
      repeat (dv[s] * 5 / 2) @(negedge clk_i);
      rd(COUNT_ADDR, 8'h02);
    end
    // From a clear at divide-by-16 the count shows FF after 4096 clocks
    // and wraps on the next one, with a one-cycle overflow pulse.
    wr(CTRL_ADDR, 8'hAF);
    repeat (4096) @(negedge clk_i);
    chk(count_o, 8'hFF);
    chk({7'h00, overflow_o}, 8'h00);
    @(negedge clk_i);
    chk(count_o, 8'h00);
    chk({7'h00, overflow_o}, 8'h01);
    @(negedge clk_i);
    chk({7'h00, overflow_o}, 8'h00);
    // A reset in mid-run must bring back the armed watchdog.
    wr(CTRL_ADDR, 8'hA8);
    chk({7'h00, wdt_enable_o}, 8'h00);
    rst_i = 1'b1;
    @(negedge clk_i);
    rst_i = 1'b0;
    rd(CTRL_ADDR, CTRL_RESET);
    chk({7'h00, wdt_enable_o}, 8'h01);
    chk(count_o, COUNT_RESET);
    test_done();
  end
endmodule : tb
bind basic_timer_watchdog_control bt_wdt_asserts bt_wdt_asserts_i (.clk_i,
  .rst_i, .bus_i, .rdata_o, .wdt_enable_o, .div_clear_o, .count_o,
  .overflow_o);
